// *** hw/tsq_params.svh ***
// Constants of the trigger sequencer limit register bank.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef TSQ_PARAMS_SVH
`define TSQ_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TSQ_OFS_CONTROL 8'h00
`define TSQ_OFS_BCAST 8'h04
`define TSQ_OFS_TIMER0 8'h08
`define TSQ_OFS_TIMER1 8'h0c
`define TSQ_OFS_SDELAY 8'h10
`define TSQ_OFS_COUNT0 8'h14
`define TSQ_OFS_COUNT1 8'h18
`define TSQ_OFS_HOLD 8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define TSQ_CTL_ENABLE_BIT 0
`define TSQ_CTL_START_BIT 1
`define TSQ_CTL_BUSY_BIT 2
`define TSQ_BTE_CLK1_BIT 4
`define TSQ_BTE_TSS_LSB 0
`define TSQ_BTE_TSS_MSB 3
`define TSQ_STEP_CMD_MSB 7
`define TSQ_STEP_CMD_LSB 4
`define TSQ_STEP_OPT_MSB 3
`define TSQ_STEP_OPT_LSB 0
`define TSQ_COPY_FLAG_BIT 3

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define TSQ_CMD_CONTROL 4'h0
`define TSQ_CMD_ADD_COPY 4'h1
`define TSQ_OPT_BROADCAST 4'hf
`define TSQ_RESET_WORD 16'h0000
`define TSQ_RESET_BTE 8'h00
`define TSQ_STEP_BASE_DELAY 16'h0001

`endif

// *** hw/tsq_pkg.sv ***
// Types shared by the trigger sequencer limit register bank.
// Assumes tsq_params.svh is on the include path.
package tsq_pkg;

    // Copy step targets, in the order of the low option bits
    typedef enum logic [2:0] {
        TSQ_TGT_TIMER0,
        TSQ_TGT_TIMER1,
        TSQ_TGT_COUNT0,
        TSQ_TGT_COUNT1,
        TSQ_TGT_SDELAY,
        TSQ_TGT_LITERAL,
        TSQ_TGT_NONE6,
        TSQ_TGT_NONE7
    } tsq_target_t;

    typedef enum logic {
        TSQ_DLY_IDLE,
        TSQ_DLY_COUNT
    } tsq_dly_state_t;

endpackage

// *** hw/tsq_step_delay.sv ***
// Step delay timer: times each step as the delay limit plus one clock.
// Assumes start comes from the same clock.
`include "tsq_params.svh"

module tsq_step_delay (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [15:0] delay_limit,
    output logic busy,
    output logic done
);

    tsq_pkg::tsq_dly_state_t state_ff;
    tsq_pkg::tsq_dly_state_t nxt_state;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // ****************************************************************
    // Counter
    // ****************************************************************
    // A start while counting is ignored: the core must wait for done
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        unique case (state_ff)
            tsq_pkg::TSQ_DLY_IDLE: begin
                if (start) begin
                    nxt_state = tsq_pkg::TSQ_DLY_COUNT;
                    nxt_cnt = delay_limit;
                end
            end
            tsq_pkg::TSQ_DLY_COUNT: begin
                // Zero left means the base clock has just elapsed
                if (cnt_ff == `TSQ_RESET_WORD) begin
                    nxt_state = tsq_pkg::TSQ_DLY_IDLE;
                    nxt_done = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - `TSQ_STEP_BASE_DELAY;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= tsq_pkg::TSQ_DLY_IDLE;
            cnt_ff <= `TSQ_RESET_WORD;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign busy = (state_ff == tsq_pkg::TSQ_DLY_COUNT);
    assign done = done_ff;

endmodule

// *** hw/tsq_limit_regs.sv ***
// Limit and broadcast register bank of the trigger sequencer, APB slave.
// Assumes a same-clock step core: one byte per step_valid pulse,
// next only after step_done.
//
// Functional notes
// - Broadcast step pulses compare 1 clock when its clock-pulse bit is set.
// - Broadcast step pulses each compare trigger 1 to 4 per enable bits 0-3.
// - Broadcast enables used only by control step with option 1111.
// - With enable and start both set, all bank registers are read-only.
// - Sixteen-bit timer 0 limit, used only by timer 0 steps.
// - Sixteen-bit timer 1 limit, used only by timer 1 steps.
// - Sixteen-bit step delay counts extra clocks inside each step.
// - Each step lasts the step delay value plus one clock.
// - Counter 0 limit serves the counter 0 jump loop or counter 0 end.
// - Counter 1 limit serves the counter 1 jump loop or counter 1 end.
// - Copy step moves the hold word into the selected limit or literal.
// - Limit, delay and hold registers clear to zero at reset.
//
// The APB register port and the register addresses are this design's own decisions.
`include "tsq_params.svh"

module tsq_limit_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step_valid,
    input wire logic [7:0] step_byte,
    output logic step_done,
    output logic step_busy,
    output logic compare1_clock_pulse,
    output logic [3:0] compare_trigger_sync,
    output logic [15:0] timer0_limit,
    output logic [15:0] timer1_limit,
    output logic [15:0] counter0_limit,
    output logic [15:0] counter1_limit,
    output logic [15:0] step_delay_limit,
    output logic literal_load,
    output logic [15:0] literal_data,
    output logic sequencer_running
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] widen16(input logic [15:0] w);
        widen16 = {16'h0000, w};
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic enable_ff;
    logic start_ff;
    logic [7:0] bte_ff;
    logic [15:0] timer0_ff;
    logic [15:0] timer1_ff;
    logic [15:0] sdelay_ff;
    logic [15:0] count0_ff;
    logic [15:0] count1_ff;
    logic [15:0] hold_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic clk1_pulse_ff;
    logic [3:0] tss_pulse_ff;
    logic literal_load_ff;
    logic [15:0] literal_ff;
    logic running_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire logic setup_phase;
    wire logic access_done;
    wire logic locked;
    wire logic sel_control;
    wire logic sel_bcast;
    wire logic sel_timer0;
    wire logic sel_timer1;
    wire logic sel_sdelay;
    wire logic sel_count0;
    wire logic sel_count1;
    wire logic sel_hold;
    wire logic sel_any;
    wire logic bank_sel;
    wire logic wr_ok;

    assign setup_phase = psel && !penable && !pready_ff;
    assign access_done = psel && penable && pready_ff;

    // Step execution freezes the bank against software
    assign locked = enable_ff && start_ff;

    assign sel_control = hit(paddr, `TSQ_OFS_CONTROL);
    assign sel_bcast = hit(paddr, `TSQ_OFS_BCAST);
    assign sel_timer0 = hit(paddr, `TSQ_OFS_TIMER0);
    assign sel_timer1 = hit(paddr, `TSQ_OFS_TIMER1);
    assign sel_sdelay = hit(paddr, `TSQ_OFS_SDELAY);
    assign sel_count0 = hit(paddr, `TSQ_OFS_COUNT0);
    assign sel_count1 = hit(paddr, `TSQ_OFS_COUNT1);
    assign sel_hold = hit(paddr, `TSQ_OFS_HOLD);

    assign bank_sel = sel_bcast || sel_timer0 || sel_timer1 || sel_sdelay
                      || sel_count0 || sel_count1 || sel_hold;
    assign sel_any = sel_control || bank_sel;

    // Control stays writable so software can stop a running sequence
    assign wr_ok = access_done && pwrite && !pslverr_ff;

    wire logic wr_control;
    wire logic wr_bcast;
    wire logic wr_timer0;
    wire logic wr_timer1;
    wire logic wr_sdelay;
    wire logic wr_count0;
    wire logic wr_count1;
    wire logic wr_hold;

    assign wr_control = wr_ok && sel_control;
    assign wr_bcast = wr_ok && sel_bcast;
    assign wr_timer0 = wr_ok && sel_timer0;
    assign wr_timer1 = wr_ok && sel_timer1;
    assign wr_sdelay = wr_ok && sel_sdelay;
    assign wr_count0 = wr_ok && sel_count0;
    assign wr_count1 = wr_ok && sel_count1;
    assign wr_hold = wr_ok && sel_hold;

    // ****************************************************************
    // Step decode
    // ****************************************************************
    wire logic [3:0] step_cmd;
    wire logic [3:0] step_opt;
    wire logic step_take;
    wire logic is_broadcast;
    wire logic is_copy;
    wire tsq_pkg::tsq_target_t copy_tgt;
    wire logic cp_timer0;
    wire logic cp_timer1;
    wire logic cp_count0;
    wire logic cp_count1;
    wire logic cp_sdelay;
    wire logic cp_literal;
    wire logic dly_busy;

    assign step_cmd = step_byte[`TSQ_STEP_CMD_MSB:`TSQ_STEP_CMD_LSB];
    assign step_opt = step_byte[`TSQ_STEP_OPT_MSB:`TSQ_STEP_OPT_LSB];

    // Steps count only while running and between step delays
    assign step_take = step_valid && running_ff && !dly_busy;

    assign is_broadcast = step_take && (step_cmd == `TSQ_CMD_CONTROL)
                          && (step_opt == `TSQ_OPT_BROADCAST);
    assign is_copy = step_take && (step_cmd == `TSQ_CMD_ADD_COPY)
                     && step_opt[`TSQ_COPY_FLAG_BIT];

    assign copy_tgt = tsq_pkg::tsq_target_t'(step_opt[2:0]);
    assign cp_timer0 = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_TIMER0);
    assign cp_timer1 = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_TIMER1);
    assign cp_count0 = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_COUNT0);
    assign cp_count1 = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_COUNT1);
    assign cp_sdelay = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_SDELAY);
    assign cp_literal = is_copy && (copy_tgt == tsq_pkg::TSQ_TGT_LITERAL);

    // ****************************************************************
    // Read data and error answer
    // ****************************************************************
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (!pwrite) begin
            if (sel_control) begin
                nxt_prdata[`TSQ_CTL_ENABLE_BIT] = enable_ff;
                nxt_prdata[`TSQ_CTL_START_BIT] = start_ff;
                nxt_prdata[`TSQ_CTL_BUSY_BIT] = dly_busy;
            end else if (sel_bcast) begin
                nxt_prdata = {24'h00_0000, bte_ff};
            end else if (sel_timer0) begin
                nxt_prdata = widen16(timer0_ff);
            end else if (sel_timer1) begin
                nxt_prdata = widen16(timer1_ff);
            end else if (sel_sdelay) begin
                nxt_prdata = widen16(sdelay_ff);
            end else if (sel_count0) begin
                nxt_prdata = widen16(count0_ff);
            end else if (sel_count1) begin
                nxt_prdata = widen16(count1_ff);
            end else if (sel_hold) begin
                nxt_prdata = widen16(hold_ff);
            end
        end
    end

    // Unmapped reads and writes, and frozen-bank writes, answer with an error
    always_comb begin
        nxt_pslverr = !sel_any;
        if (pwrite && bank_sel && locked) begin
            nxt_pslverr = 1'b1;
        end
    end

    // ****************************************************************
    // APB answer: no wait states, pready from a flop
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_phase;
            if (setup_phase) begin
                pslverr_ff <= nxt_pslverr;
                prdata_ff <= nxt_prdata;
            end else if (access_done) begin
                pslverr_ff <= 1'b0;
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= 1'b0;
            start_ff <= 1'b0;
            running_ff <= 1'b0;
        end else begin
            if (wr_control) begin
                enable_ff <= pwdata[`TSQ_CTL_ENABLE_BIT];
                start_ff <= pwdata[`TSQ_CTL_START_BIT];
            end
            running_ff <= locked;
        end
    end

    // ****************************************************************
    // Bank registers
    // ****************************************************************
    // Software and copy steps never meet: software writes need the bank
    // unlocked, copy steps need it running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bte_ff <= `TSQ_RESET_BTE;
            hold_ff <= `TSQ_RESET_WORD;
        end else begin
            if (wr_bcast) begin
                bte_ff <= pwdata[7:0];
            end
            if (wr_hold) begin
                hold_ff <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_ff <= `TSQ_RESET_WORD;
            timer1_ff <= `TSQ_RESET_WORD;
        end else begin
            if (wr_timer0 || cp_timer0) begin
                timer0_ff <= cp_timer0 ? hold_ff : pwdata[15:0];
            end
            if (wr_timer1 || cp_timer1) begin
                timer1_ff <= cp_timer1 ? hold_ff : pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count0_ff <= `TSQ_RESET_WORD;
            count1_ff <= `TSQ_RESET_WORD;
        end else begin
            if (wr_count0 || cp_count0) begin
                count0_ff <= cp_count0 ? hold_ff : pwdata[15:0];
            end
            if (wr_count1 || cp_count1) begin
                count1_ff <= cp_count1 ? hold_ff : pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdelay_ff <= `TSQ_RESET_WORD;
        end else if (wr_sdelay || cp_sdelay) begin
            sdelay_ff <= cp_sdelay ? hold_ff : pwdata[15:0];
        end
    end

    // ****************************************************************
    // Broadcast and literal pulses
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk1_pulse_ff <= 1'b0;
            tss_pulse_ff <= 4'h0;
            literal_load_ff <= 1'b0;
            literal_ff <= `TSQ_RESET_WORD;
        end else begin
            clk1_pulse_ff <= is_broadcast && bte_ff[`TSQ_BTE_CLK1_BIT];
            tss_pulse_ff <= is_broadcast ? bte_ff[`TSQ_BTE_TSS_MSB:`TSQ_BTE_TSS_LSB] : 4'h0;
            literal_load_ff <= cp_literal;
            if (cp_literal) begin
                literal_ff <= hold_ff;
            end
        end
    end

    // ****************************************************************
    // Step timing
    // ****************************************************************
    // A copy lands as its delay starts, so the
    // next step sees the new limit.
    tsq_step_delay u_step_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(step_take),
        .delay_limit(sdelay_ff),
        .busy(dly_busy),
        .done(step_done)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign step_busy = dly_busy;
    assign compare1_clock_pulse = clk1_pulse_ff;
    assign compare_trigger_sync = tss_pulse_ff;
    assign timer0_limit = timer0_ff;
    assign timer1_limit = timer1_ff;
    assign counter0_limit = count0_ff;
    assign counter1_limit = count1_ff;
    assign step_delay_limit = sdelay_ff;
    assign literal_load = literal_load_ff;
    assign literal_data = literal_ff;
    assign sequencer_running = running_ff;

endmodule

// *** tb/tsq_limit_regs_sva.sv ***
// Checker of the limit register bank, bound to its top.
// Assumes one clock and the bank's APB and step timing.
`include "tsq_params.svh"

module tsq_limit_regs_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic step_valid,
    input wire logic [7:0] step_byte,
    input wire logic step_done,
    input wire logic step_busy,
    input wire logic compare1_clock_pulse,
    input wire logic [3:0] compare_trigger_sync,
    input wire logic [15:0] timer0_limit,
    input wire logic [15:0] timer1_limit,
    input wire logic [15:0] counter0_limit,
    input wire logic [15:0] counter1_limit,
    input wire logic [15:0] step_delay_limit,
    input wire logic literal_load,
    input wire logic [15:0] literal_data,
    input wire logic sequencer_running
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Software shadows and step length
    // ********
    logic [15:0] hold_ff;
    logic [4:0] bte_ff;
    logic [15:0] sdl_ff;
    logic [16:0] busy_cnt_ff;
    wire acc_wr = psel && penable && pready && pwrite;
    wire wr_ok = acc_wr && !pslverr;
    wire take = step_valid && sequencer_running && !step_busy;
    // Running trails control by one edge; accesses are two edges apart
    wire locked_wr = acc_wr && paddr != `TSQ_OFS_CONTROL && sequencer_running;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= 16'h0000;
            bte_ff <= 5'h00;
        end else if (wr_ok && paddr == `TSQ_OFS_HOLD) begin
            hold_ff <= pwdata[15:0];
        end else if (wr_ok && paddr == `TSQ_OFS_BCAST) begin
            bte_ff <= pwdata[4:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdl_ff <= 16'h0000;
            busy_cnt_ff <= 17'h00000;
        end else if (take) begin
            sdl_ff <= step_delay_limit;
            busy_cnt_ff <= 17'h00000;
        end else if (step_busy) begin
            busy_cnt_ff <= busy_cnt_ff + 17'h00001;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_bcast;
        take && step_byte == {`TSQ_CMD_CONTROL, `TSQ_OPT_BROADCAST};
    endsequence
    sequence s_copy(logic [2:0] tgt);
        take && step_byte == {`TSQ_CMD_ADD_COPY, 1'b1, tgt};
    endsequence
    property p_apb_ready;
        psel && !penable |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no pready");
    property p_bcast_clk;
        s_bcast |=> compare1_clock_pulse == bte_ff[4];
    endproperty
    a_bcast_clk: assert property (p_bcast_clk) else $error("clock pulse");
    property p_bcast_trig;
        s_bcast |=> compare_trigger_sync == bte_ff[3:0];
    endproperty
    a_bcast_trig: assert property (p_bcast_trig) else $error("triggers");
    property p_other_quiet;
        take && step_byte != 8'h0f |=> compare_trigger_sync == 4'h0 && !compare1_clock_pulse;
    endproperty
    a_other_quiet: assert property (p_other_quiet) else $error("stray pulse");
    property p_lock;
        locked_wr |-> pslverr ##1 $stable({timer0_limit, timer1_limit, counter0_limit, counter1_limit});
    endproperty
    a_lock: assert property (p_lock) else $error("locked write");
    property p_reset_zero;
        $rose(presetn) |-> {timer0_limit, timer1_limit, counter0_limit, counter1_limit, step_delay_limit} == 80'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value");
    property p_step_start;
        take |=> step_busy && !step_done;
    endproperty
    a_step_start: assert property (p_step_start) else $error("step start");
    property p_step_len;
        step_done |-> !step_busy && busy_cnt_ff == {1'b0, sdl_ff} + 17'h00001;
    endproperty
    a_step_len: assert property (p_step_len) else $error("step length wrong");
    property p_copy_t0;
        s_copy(3'h0) |=> timer0_limit == hold_ff;
    endproperty
    a_copy_t0: assert property (p_copy_t0) else $error("copy t0");
    property p_copy_sd;
        s_copy(3'h4) |=> step_delay_limit == hold_ff;
    endproperty
    a_copy_sd: assert property (p_copy_sd) else $error("copy delay");
    property p_copy_lit;
        s_copy(3'h5) |=> literal_load && literal_data == hold_ff;
    endproperty
    a_copy_lit: assert property (p_copy_lit) else $error("copy literal");
endmodule

bind tsq_limit_regs tsq_limit_regs_sva u_sva (.*);

// *** tb/tsq_step_core_model.sv ***
// Step core model: presents a step byte, watches the step's outputs.
// Assumes one step at a time, next after done.
module tsq_step_core_model (
    input wire logic pclk,
    output logic step_valid,
    output logic [7:0] step_byte,
    input wire logic step_done,
    input wire logic step_busy,
    input wire logic compare1_clock_pulse,
    input wire logic [3:0] compare_trigger_sync,
    input wire logic literal_load
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        step_valid = 1'b0;
        step_byte = 8'h00;
    end
    // ********
    // One step; an ignored one runs out the wait
    // ********
    task automatic issue(input logic [7:0] b, output int busy_n, output logic clk_seen,
                         output logic [3:0] trig_seen, output logic lit_seen);
        busy_n = 0;
        clk_seen = 1'b0;
        trig_seen = 4'h0;
        lit_seen = 1'b0;
        @(posedge pclk);
        step_valid <= 1'b1;
        step_byte <= b;
        @(posedge pclk);
        step_valid <= 1'b0;
        // Released lines show the inverse
        step_byte <= ~b;
        for (int i = 0; i < 100; i++) begin
            @(negedge pclk);
            clk_seen = clk_seen | compare1_clock_pulse;
            trig_seen = trig_seen | compare_trigger_sync;
            lit_seen = lit_seen | literal_load;
            if (step_done === 1'b1) begin
                break;
            end
            busy_n += int'(step_busy === 1'b1);
        end
    endtask
endmodule

// *** tb/tsq_limit_regs_tb.sv ***
// Limit register bank bench: APB master plus step core model.
// Assumes design and checker compiled first.
`include "tsq_params.svh"

module tsq_limit_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, step_valid, step_done, step_busy, compare1_clock_pulse, literal_load;
    logic sequencer_running, c, l;
    logic [7:0] step_byte;
    logic [3:0] compare_trigger_sync, t;
    logic [15:0] timer0_limit, timer1_limit, counter0_limit, counter1_limit, step_delay_limit, literal_data;
    int n;
    int err_count = 0;
    int comparisons = 0;
    localparam logic [7:0] OFS [6] = '{`TSQ_OFS_TIMER0, `TSQ_OFS_TIMER1, `TSQ_OFS_COUNT0,
                                       `TSQ_OFS_COUNT1, `TSQ_OFS_SDELAY, `TSQ_OFS_HOLD};
    localparam logic [15:0] SD [4] = '{16'h0000, 16'h0001, 16'h0007, 16'h0020};
    localparam logic [7:0] BTE [5] = '{8'h10, 8'h0a, 8'h05, 8'h00, 8'h1f};
    localparam logic [7:0] NB [4] = '{8'h00, 8'h0e, 8'h1f, 8'hff};

    always #2 pclk = ~pclk;

    tsq_limit_regs DUT (.*);
    tsq_step_core_model u_core (.*);

    // ********
    // Shared tasks
    // ********
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Two edges let running catch up
    task automatic run(input logic on);
        apb(1'b1, `TSQ_OFS_CONTROL, {30'h0, on, on});
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [15:0] lim(input int i);
        case (i)
            0: return timer0_limit;
            1: return timer1_limit;
            2: return counter0_limit;
            3: return counter1_limit;
            default: return step_delay_limit;
        endcase
    endfunction
    task automatic print_verdict;
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset_values;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, OFS[i], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_limit_rw;
        logic [15:0] v;
        for (int i = 0; i < 5; i++) begin
            v = 16'ha5c3 ^ 16'(i);
            apb(1'b1, OFS[i], {16'hdead, v});
            apb(1'b0, OFS[i], 32'h0);
            chk("limit read", {16'h0, v}, rd);
            chk("limit port", {16'h0, v}, {16'h0, lim(i)});
        end
    endtask
    task automatic t_lock;
        run(1'b1);
        chk("running", 32'h1, {31'h0, sequencer_running});
        apb(1'b1, `TSQ_OFS_TIMER0, 32'h4242);
        chk("locked err", 32'h1, {31'h0, er});
        chk("locked value", 32'ha5c3, {16'h0, timer0_limit});
        run(1'b0);
        chk("control err", 32'h0, {31'h0, er});
    endtask
    task automatic t_delay;
        for (int i = 0; i < 4; i++) begin
            run(1'b0);
            apb(1'b1, `TSQ_OFS_SDELAY, {16'h0, SD[i]});
            run(1'b1);
            u_core.issue(8'h0e, n, c, t, l);
            chk("step length", {16'h0, SD[i]} + 32'h1, 32'(n));
        end
    endtask
    task automatic t_broadcast;
        for (int i = 0; i < 5; i++) begin
            run(1'b0);
            apb(1'b1, `TSQ_OFS_BCAST, {24'h0, BTE[i]});
            run(1'b1);
            u_core.issue(8'h0f, n, c, t, l);
            chk("clock pulse", {31'h0, BTE[i][4]}, {31'h0, c});
            chk("trigger pulses", {28'h0, BTE[i][3:0]}, {28'h0, t});
        end
        for (int j = 0; j < 4; j++) begin
            u_core.issue(NB[j], n, c, t, l);
            chk("quiet pulses", 32'h0, {27'h0, c, t});
        end
    endtask
    task automatic t_copy;
        run(1'b0);
        apb(1'b1, `TSQ_OFS_SDELAY, 32'h0);
        apb(1'b1, `TSQ_OFS_HOLD, 32'h0025);
        run(1'b1);
        for (int i = 0; i < 6; i++) begin
            u_core.issue(8'h18 | 8'(i), n, c, t, l);
            if (i < 5) chk("copy target", 32'h25, {16'h0, lim(i)});
            else chk("literal", 32'h10025, {15'h0, l, literal_data});
        end
        chk("delay after copy", 32'h26, 32'(n));
        run(1'b0);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_limit_rw();
        t_lock();
        t_delay();
        t_broadcast();
        t_copy();
        print_verdict();
    end
    // Run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end
endmodule
